// ===== src/lsr_pkg.sv
// constants for the led sequencer control and status register bank
// assumes a byte-wide register access port decoded by an upstream serial bus slave
package lsr_pkg;
	// register offsets
	localparam logic [7:0] OFS_MISC     = 8'h36;
	localparam logic [7:0] OFS_ENG1_PC  = 8'h37;
	localparam logic [7:0] OFS_ENG2_PC  = 8'h38;
	localparam logic [7:0] OFS_ENG3_PC  = 8'h39;
	localparam logic [7:0] OFS_STATUS   = 8'h3a;
	localparam logic [7:0] OFS_GPO      = 8'h3b;
	localparam logic [7:0] OFS_GVAR     = 8'h3c;
	localparam logic [7:0] OFS_SWRST    = 8'h3d;
	localparam logic [7:0] OFS_TEMPCTL  = 8'h3e;
	localparam logic [7:0] OFS_TEMPRD   = 8'h3f;
	localparam logic [7:0] OFS_TEMPWR   = 8'h40;
	localparam logic [7:0] OFS_LEDTEST  = 8'h41;
	localparam logic [7:0] OFS_LEDRES   = 8'h42;
	// reset values
	localparam logic [7:0] RST_ZERO     = 8'h00;
	localparam logic [7:0] RST_STATUS   = 8'h40;
	localparam logic [7:0] SWRST_CODE   = 8'hff;
	// field positions
	localparam int ST_DONE   = 7;
	localparam int ST_MASK   = 6;
	localparam int ST_BOOT   = 5;
	localparam int ST_CLEAR  = 4;
	localparam int ST_EXTCLK = 3;
	localparam int GP_CONF   = 2;
	localparam int GP_GPO    = 1;
	localparam int GP_INTLV  = 0;
	localparam int TC_BUSY   = 7;
	localparam int TC_EN     = 2;
	localparam int TC_CONT   = 1;
	localparam int TC_EXT    = 0;
	localparam int LT_START  = 7;
	localparam int LT_IRQEN  = 6;
	localparam int LT_CONT   = 5;
	localparam int MISC_DPS  = 2;
	// program clock source codes
	localparam logic [1:0] CLK_FORCE_EXT = 2'h0;
	localparam logic [1:0] CLK_FORCE_INT = 2'h1;
	localparam logic [1:0] CLK_AUTO      = 2'h2;
	localparam logic [1:0] CLK_INT       = 2'h3;
	// limits
	localparam logic [6:0] PC_MAX        = 7'h5f;
	localparam logic [7:0] TEMP_HI       = 8'h59;
	localparam logic [7:0] TEMP_LO       = 8'hd9;
	localparam logic [4:0] CH_D9         = 5'h08;
	localparam logic [4:0] CH_VOUT       = 5'h0f;
	localparam logic [4:0] CH_IRQ        = 5'h11;
	// timing
	localparam int CLK_MHZ       = 100;
	localparam int LED_TEST_US   = 2700;
	localparam int TEMP_MEAS_US  = 20000;
	localparam int LED_TEST_CYC  = LED_TEST_US * CLK_MHZ;
	localparam int TEMP_MEAS_CYC = TEMP_MEAS_US * CLK_MHZ;
	localparam int CLKDET_CYC    = 8192;
endpackage : lsr_pkg

// ===== src/lsr_regs.sv
// register bank for program clock, engine start counters, status, outputs,
// temperature and led_check_channel
// assumes reg_* strobes come from a serial bus slave, one cycle each, in mclk_i domain
`timescale 1ns/1ps
module lsr_regs #(
	parameter int LED_TEST_CYCLES = lsr_pkg::LED_TEST_CYC,
	parameter int TEMP_CYCLES     = lsr_pkg::TEMP_MEAS_CYC,
	parameter int CLKDET_CYCLES   = lsr_pkg::CLKDET_CYC
) (
	// clock and reset
	input  wire logic       mclk_i,
	input  wire logic       sys_rst_i,
	// register access port
	input  wire logic [7:0] reg_addr_i,
	input  wire logic [7:0] reg_wdata_i,
	input  wire logic       reg_wr_i,
	input  wire logic       reg_rd_i,
	output logic      [7:0] reg_rdata_o,
	// chip state and engine events
	input  wire logic       chip_enable_i,
	input  wire logic       boot_running_i,
	input  wire logic       engine_clearing_i,
	input  wire logic [2:0] engine_irq_i,
	input  wire logic       power_save_i,
	// timebase pin (sampled synchronously)
	input  wire logic       timebase_pin_i,
	// analog results
	input  wire logic [7:0] temp_result_i,
	input  wire logic [7:0] led_result_i,
	// control outputs
	output logic      [1:0] clk_source_o,
	output logic            use_ext_clk_o,
	output logic            duty_powersave_enable_o,
	output logic      [6:0] program_counter_start1_o,
	output logic      [6:0] program_counter_start2_o,
	output logic      [6:0] program_counter_start3_o,
	output logic      [7:0] global_var_o,
	output logic      [7:0] comp_temp_o,
	output logic      [4:0] led_check_channel_o,
	output logic            led_check_run_o,
	output logic            temp_run_o,
	output logic            sw_reset_o,
	// pins
	output logic            general_output_pin_o,
	output logic            irq_pin_o,
	output logic            irq_pin_oe_o
);
	logic [7:0] misc_ff, pc1_ff, pc2_ff, pc3_ff, gpo_ff, gvar_ff, tctl_ff, tint_ff, text_ff;
	logic [7:0] ltc_ff, lres_ff;
	logic       done_ff, mask_ff, rdy_ff, boot_d_ff, clr_d_ff;
	logic [2:0] eng_ff;
	logic       tbp_ff, det_ff;
	logic [31:0] lt_cnt_ff, tm_cnt_ff, det_cnt_ff;
	logic       lt_busy_ff, tm_busy_ff, ps_d_ff, swr_ff;

	// clamp host-written temperature into the compensation range
	function automatic logic [7:0] sat_temp(input logic [7:0] v);
		if (!v[7] && v > lsr_pkg::TEMP_HI)
			sat_temp = lsr_pkg::TEMP_HI;
		else if (v[7] && v < lsr_pkg::TEMP_LO)
			sat_temp = lsr_pkg::TEMP_LO;
		else
			sat_temp = v;
	endfunction : sat_temp

	function automatic logic [6:0] clip_pc(input logic [7:0] v);
		clip_pc = (v[6:0] > lsr_pkg::PC_MAX) ? lsr_pkg::PC_MAX : v[6:0];
	endfunction : clip_pc

	wire wr_misc  = reg_wr_i && reg_addr_i == lsr_pkg::OFS_MISC;
	wire wr_pc1   = reg_wr_i && reg_addr_i == lsr_pkg::OFS_ENG1_PC;
	wire wr_pc2   = reg_wr_i && reg_addr_i == lsr_pkg::OFS_ENG2_PC;
	wire wr_pc3   = reg_wr_i && reg_addr_i == lsr_pkg::OFS_ENG3_PC;
	wire wr_stat  = reg_wr_i && reg_addr_i == lsr_pkg::OFS_STATUS;
	wire wr_gpo   = reg_wr_i && reg_addr_i == lsr_pkg::OFS_GPO;
	wire wr_gvar  = reg_wr_i && reg_addr_i == lsr_pkg::OFS_GVAR;
	wire wr_tctl  = reg_wr_i && reg_addr_i == lsr_pkg::OFS_TEMPCTL;
	wire wr_text  = reg_wr_i && reg_addr_i == lsr_pkg::OFS_TEMPWR;
	wire wr_ltc   = reg_wr_i && reg_addr_i == lsr_pkg::OFS_LEDTEST;
	wire do_swrst = reg_wr_i && reg_addr_i == lsr_pkg::OFS_SWRST
	                && reg_wdata_i == lsr_pkg::SWRST_CODE;
	wire rd_stat  = reg_rd_i && reg_addr_i == lsr_pkg::OFS_STATUS;
	wire rst_all  = sys_rst_i || swr_ff;

	// detector enable is the upper clock-source bit
	wire det_en   = misc_ff[1];
	wire boot_now = boot_running_i || !chip_enable_i;
	wire boot_end = boot_d_ff && !boot_now;
	wire clr_end  = clr_d_ff && !engine_clearing_i;
	wire lt_fin   = lt_busy_ff && lt_cnt_ff == 32'd1;
	wire tm_fin   = tm_busy_ff && tm_cnt_ff == 32'd1;
	wire ps_exit  = ps_d_ff && !power_save_i;
	wire lt_go    = (wr_ltc && reg_wdata_i[lsr_pkg::LT_START])
	                || (lt_fin && ltc_ff[lsr_pkg::LT_CONT] && !power_save_i);
	wire tm_go    = (wr_tctl && reg_wdata_i[lsr_pkg::TC_EN])
	                || (tctl_ff[lsr_pkg::TC_EN] && tm_fin
	                    && tctl_ff[lsr_pkg::TC_CONT] && !power_save_i)
	                || (tctl_ff[lsr_pkg::TC_EN] && ps_exit && !tm_busy_ff);
	wire [7:0] status_w = {done_ff, mask_ff, boot_now, engine_clearing_i,
	                       det_en && det_ff, eng_ff};
	// irq stays low while any enabled source is pending
	wire irq_pend = (|eng_ff) || (rdy_ff && !mask_ff)
	                || (done_ff && ltc_ff[lsr_pkg::LT_IRQEN]);

	always_ff @(posedge mclk_i) begin
		if (rst_all) begin
			misc_ff   <= lsr_pkg::RST_ZERO;
			pc1_ff    <= lsr_pkg::RST_ZERO;
			pc2_ff    <= lsr_pkg::RST_ZERO;
			pc3_ff    <= lsr_pkg::RST_ZERO;
			gpo_ff    <= lsr_pkg::RST_ZERO;
			gvar_ff   <= lsr_pkg::RST_ZERO;
			tctl_ff   <= lsr_pkg::RST_ZERO;
			text_ff   <= lsr_pkg::RST_ZERO;
			ltc_ff    <= lsr_pkg::RST_ZERO;
			mask_ff   <= lsr_pkg::RST_STATUS[lsr_pkg::ST_MASK];
		end else begin
			if (wr_misc)
				misc_ff <= reg_wdata_i;
			if (wr_pc1)
				pc1_ff <= {1'b0, clip_pc(reg_wdata_i)};
			if (wr_pc2)
				pc2_ff <= {1'b0, clip_pc(reg_wdata_i)};
			if (wr_pc3)
				pc3_ff <= {1'b0, clip_pc(reg_wdata_i)};
			if (wr_stat)
				mask_ff <= reg_wdata_i[lsr_pkg::ST_MASK];
			if (wr_gpo)
				gpo_ff <= {5'h00, reg_wdata_i[2:0]};
			if (wr_gvar)
				gvar_ff <= reg_wdata_i;
			if (wr_tctl)
				tctl_ff <= {1'b0, 4'h0, reg_wdata_i[2:0]};
			if (wr_text)
				text_ff <= sat_temp(reg_wdata_i);
			if (wr_ltc)
				ltc_ff <= {1'b0, reg_wdata_i[6:0]};
		end
	end

	// sticky flags: a set in the same cycle as the status read wins
	always_ff @(posedge mclk_i) begin
		if (rst_all) begin
			done_ff   <= 1'b0;
			rdy_ff    <= 1'b0;
			eng_ff    <= 3'h0;
			boot_d_ff <= 1'b1;
			clr_d_ff  <= 1'b0;
			ps_d_ff   <= 1'b0;
		end else begin
			done_ff   <= lt_fin || (done_ff && !rd_stat);
			rdy_ff    <= boot_end || clr_end || (rdy_ff && !rd_stat);
			eng_ff    <= engine_irq_i | (eng_ff & {3{!rd_stat}});
			boot_d_ff <= boot_now;
			clr_d_ff  <= engine_clearing_i;
			ps_d_ff   <= power_save_i;
		end
	end

	// conversion timers stand in for the analog converters
	always_ff @(posedge mclk_i) begin
		if (rst_all) begin
			lt_busy_ff <= 1'b0;
			lt_cnt_ff  <= 32'd0;
			tm_busy_ff <= 1'b0;
			tm_cnt_ff  <= 32'd0;
			lres_ff    <= lsr_pkg::RST_ZERO;
			tint_ff    <= lsr_pkg::RST_ZERO;
		end else begin
			if (lt_go) begin
				lt_busy_ff <= 1'b1;
				lt_cnt_ff  <= 32'(LED_TEST_CYCLES);
			end else if (lt_busy_ff) begin
				lt_cnt_ff  <= lt_cnt_ff - 32'd1;
				lt_busy_ff <= !lt_fin;
			end
			if (lt_fin)
				lres_ff <= led_result_i;
			if (tm_go) begin
				tm_busy_ff <= 1'b1;
				tm_cnt_ff  <= 32'(TEMP_CYCLES);
			end else if (tm_busy_ff) begin
				tm_cnt_ff  <= tm_cnt_ff - 32'd1;
				tm_busy_ff <= !tm_fin;
			end
			if (tm_fin)
				tint_ff <= temp_result_i;
		end
	end

	// edge seen on the timebase pin restarts a timeout; silence clears detect
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			tbp_ff     <= 1'b0;
			det_ff     <= 1'b0;
			det_cnt_ff <= 32'd0;
			swr_ff     <= 1'b0;
		end else begin
			tbp_ff <= timebase_pin_i;
			swr_ff <= do_swrst;
			if (!det_en) begin
				det_ff     <= 1'b0;
				det_cnt_ff <= 32'd0;
			end else if (tbp_ff != timebase_pin_i) begin
				det_ff     <= 1'b1;
				det_cnt_ff <= 32'(CLKDET_CYCLES);
			end else if (det_cnt_ff != 32'd0) begin
				det_cnt_ff <= det_cnt_ff - 32'd1;
			end else begin
				det_ff <= 1'b0;
			end
		end
	end

	// read mux; reset register and unmapped offsets read zero
	always_comb begin
		case (reg_addr_i)
			lsr_pkg::OFS_MISC:    reg_rdata_o = misc_ff;
			lsr_pkg::OFS_ENG1_PC: reg_rdata_o = pc1_ff;
			lsr_pkg::OFS_ENG2_PC: reg_rdata_o = pc2_ff;
			lsr_pkg::OFS_ENG3_PC: reg_rdata_o = pc3_ff;
			lsr_pkg::OFS_STATUS:  reg_rdata_o = status_w;
			lsr_pkg::OFS_GPO:     reg_rdata_o = gpo_ff;
			lsr_pkg::OFS_GVAR:    reg_rdata_o = gvar_ff;
			lsr_pkg::OFS_SWRST:   reg_rdata_o = lsr_pkg::RST_ZERO;
			lsr_pkg::OFS_TEMPCTL: reg_rdata_o = {tm_busy_ff, tctl_ff[6:0]};
			lsr_pkg::OFS_TEMPRD:  reg_rdata_o = tint_ff;
			lsr_pkg::OFS_TEMPWR:  reg_rdata_o = text_ff;
			lsr_pkg::OFS_LEDTEST: reg_rdata_o = ltc_ff;
			lsr_pkg::OFS_LEDRES:  reg_rdata_o = lres_ff;
			default:              reg_rdata_o = lsr_pkg::RST_ZERO;
		endcase
	end

	// automatic selection falls back to internal when no edges are seen
	assign clk_source_o             = misc_ff[1:0];
	assign use_ext_clk_o            = misc_ff[1:0] == lsr_pkg::CLK_FORCE_EXT
	                                  || (misc_ff[1:0] == lsr_pkg::CLK_AUTO && det_ff);
	assign duty_powersave_enable_o  = misc_ff[lsr_pkg::MISC_DPS];
	assign program_counter_start1_o = pc1_ff[6:0];
	assign program_counter_start2_o = pc2_ff[6:0];
	assign program_counter_start3_o = pc3_ff[6:0];
	assign global_var_o             = gvar_ff;
	assign comp_temp_o = tctl_ff[lsr_pkg::TC_EXT] ? text_ff : tint_ff;
	assign led_check_channel_o      = ltc_ff[4:0];
	assign led_check_run_o          = lt_busy_ff;
	assign temp_run_o               = tm_busy_ff;
	assign sw_reset_o               = swr_ff;
	assign general_output_pin_o     = gpo_ff[lsr_pkg::GP_GPO];
	// as an interrupt the pin only ever pulls low
	assign irq_pin_o    = gpo_ff[lsr_pkg::GP_CONF] ? gpo_ff[lsr_pkg::GP_INTLV] : 1'b0;
	assign irq_pin_oe_o = gpo_ff[lsr_pkg::GP_CONF] ? 1'b1 : irq_pend;
endmodule : lsr_regs

// ===== bench/lsr_regs_asserts.sv
// port checker for the led sequencer register bank
// assumes it is bound onto lsr_regs, one clock domain, sync reset
`timescale 1ns/1ps
module lsr_regs_asserts #(
	parameter int LED_TEST_CYCLES = 20
) (
	// clock, reset and access port
	input wire logic       mclk_i,
	input wire logic       sys_rst_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic       reg_wr_i,
	input wire logic       reg_rd_i,
	input wire logic [7:0] reg_rdata_o,
	// state, events and outputs
	input wire logic       chip_enable_i,
	input wire logic [2:0] engine_irq_i,
	input wire logic [6:0] program_counter_start1_o,
	input wire logic       led_check_run_o,
	input wire logic       temp_run_o,
	input wire logic       sw_reset_o,
	input wire logic       general_output_pin_o,
	input wire logic       irq_pin_o,
	input wire logic       irq_pin_oe_o
);
	logic [31:0] run_cnt_ff;
	logic [31:0] nxt_run_cnt;
	wire         st_sel = reg_addr_i == 8'h3a;
	wire         wr_sel = reg_wr_i;
	assign nxt_run_cnt = led_check_run_o ? run_cnt_ff + 32'h0000_0001 : 32'h0000_0000;
	always_ff @(posedge mclk_i) begin
		run_cnt_ff <= sys_rst_i ? 32'h0000_0000 : nxt_run_cnt;
	end
	default clocking @(posedge mclk_i); endclocking
	default disable iff (sys_rst_i);
	a_swrst_pulse:
		assert property (wr_sel && reg_addr_i == 8'h3d && reg_wdata_i == 8'hff |=> sw_reset_o)
		else $error("software reset pulse missing");
	a_dead_reads:
		assert property (reg_addr_i == 8'h3d || reg_addr_i > 8'h42 || reg_addr_i < 8'h36
			|-> reg_rdata_o == 8'h00) else $error("unmapped or reset offset read not zero");
	a_gpo_levels:
		assert property (wr_sel && reg_addr_i == 8'h3b |=> general_output_pin_o ==
			$past(reg_wdata_i[1]) && (!$past(reg_wdata_i[2]) || irq_pin_oe_o &&
			irq_pin_o == $past(reg_wdata_i[0]))) else $error("output pin levels wrong");
	a_pc_clip:
		assert property (wr_sel && reg_addr_i == 8'h37 |=> program_counter_start1_o ==
			($past(reg_wdata_i) > 8'h5f ? 7'h5f : $past(reg_wdata_i[6:0])))
		else $error("start counter value wrong");
	a_led_start:
		assert property (wr_sel && reg_addr_i == 8'h41 && reg_wdata_i[7] |=> led_check_run_o)
		else $error("led check did not start");
	a_led_run_len:
		assert property ($fell(led_check_run_o) |-> run_cnt_ff + 1 >= LED_TEST_CYCLES &&
			run_cnt_ff <= LED_TEST_CYCLES + 1) else $error("led check length wrong");
	a_done_flag:
		assert property ($fell(led_check_run_o) ##1 st_sel |-> reg_rdata_o[7])
		else $error("led check done flag not set");
	a_temp_start:
		assert property (wr_sel && reg_addr_i == 8'h3e && reg_wdata_i[2] |=> temp_run_o)
		else $error("temperature measure did not start");
	a_boot_forced:
		assert property (!chip_enable_i && st_sel |-> reg_rdata_o[5])
		else $error("boot bit low while chip disabled");
	a_eng_set:
		assert property (engine_irq_i[0] ##1 st_sel |-> reg_rdata_o[0])
		else $error("engine flag not set");
	a_eng_clear:
		assert property (reg_rd_i && st_sel && engine_irq_i == 3'h0 ##1 st_sel
			|-> reg_rdata_o[2:0] == 3'h0) else $error("engine flags not cleared by read");
endmodule : lsr_regs_asserts

bind lsr_regs lsr_regs_asserts #(.LED_TEST_CYCLES(LED_TEST_CYCLES)) u_chk (.*);

// ===== bench/lsr_far_model.sv
// far-side model: outside timebase source and analog results
// assumes mclk_i is the bank clock; results are held steady
`timescale 1ns/1ps
module lsr_far_model #(
	parameter int HALF_CYC = 3
) (
	// control
	input  wire logic       mclk_i,
	input  wire logic       tb_run_i,
	// to the bank
	output logic            timebase_pin_o,
	output logic      [7:0] temp_result_o,
	output logic      [7:0] led_result_o
);
	int div_cnt = 0;
	assign temp_result_o = 8'hd7;
	assign led_result_o  = 8'ha6;
	initial timebase_pin_o = 1'b0;
	// a stopped timebase parks low, as a grounded unused pin would
	always @(posedge mclk_i) begin
		div_cnt = tb_run_i ? (div_cnt + 1) % HALF_CYC : 0;
		if (!tb_run_i) timebase_pin_o <= 1'b0;
		else if (div_cnt == 0) timebase_pin_o <= ~timebase_pin_o;
	end
endmodule : lsr_far_model

// ===== bench/led_sequencer_status_ctrl_regs_bench.sv
// self-checking bench for the led sequencer register bank
// assumes the far-side model supplies results and the outside timebase
`timescale 1ns/1ps
module led_sequencer_status_ctrl_regs_bench;
	logic       mclk_i = 1'b0;
	logic       sys_rst_i = 1'b1;
	logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o, temp_res, led_res;
	logic       reg_wr_i = 1'b0, reg_rd_i = 1'b0, chip_enable_i = 1'b1, boot_running_i = 1'b0;
	logic [2:0] engine_irq_i = 3'h0;
	logic       tb_run = 1'b0, tb_pin, use_ext_clk_o, led_check_run_o, temp_run_o;
	logic       general_output_pin_o, irq_pin_o, irq_pin_oe_o, swr;
	logic [1:0] clk_source_o;
	logic [6:0] pc1;
	logic [7:0] global_var_o, comp_temp_o;
	logic [4:0] led_check_channel_o;
	int         fail_count = 0, n_compared = 0, cyc = 0;
	logic [4:0] chans [5] = '{5'h00, 5'h08, 5'h0f, 5'h10, 5'h11};
	always #5 mclk_i = ~mclk_i;
	lsr_far_model #(.HALF_CYC(3)) far (.mclk_i(mclk_i), .tb_run_i(tb_run),
		.timebase_pin_o(tb_pin), .temp_result_o(temp_res), .led_result_o(led_res));
	// engine clearing stays low, so no access ever lands in the forbidden window
	lsr_regs #(.LED_TEST_CYCLES(20), .TEMP_CYCLES(30), .CLKDET_CYCLES(16)) uut (
		.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o), .chip_enable_i(chip_enable_i),
		.boot_running_i(boot_running_i), .engine_clearing_i(1'b0),
		.engine_irq_i(engine_irq_i), .power_save_i(1'b0), .timebase_pin_i(tb_pin),
		.temp_result_i(temp_res), .led_result_i(led_res), .clk_source_o(clk_source_o),
		.use_ext_clk_o(use_ext_clk_o), .duty_powersave_enable_o(),
		.program_counter_start1_o(pc1), .program_counter_start2_o(),
		.program_counter_start3_o(), .global_var_o(global_var_o),
		.comp_temp_o(comp_temp_o), .led_check_channel_o(led_check_channel_o),
		.led_check_run_o(led_check_run_o), .temp_run_o(temp_run_o), .sw_reset_o(swr),
		.general_output_pin_o(general_output_pin_o), .irq_pin_o(irq_pin_o),
		.irq_pin_oe_o(irq_pin_oe_o));
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		reg_addr_i  <= a;
		reg_wdata_i <= d;
		reg_wr_i    <= 1'b1;
		@(posedge mclk_i);
		reg_wr_i <= 1'b0;
		@(negedge mclk_i);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge mclk_i);
		reg_addr_i <= a;
		reg_rd_i   <= 1'b1;
		@(negedge mclk_i);
		chk(reg_rdata_o, e);
		@(posedge mclk_i);
		reg_rd_i <= 1'b0;
	endtask : rd
	// parking on the status offset lets the checker watch flags while waiting
	task automatic idle(input int n);
		repeat (n) begin
			@(posedge mclk_i);
			reg_addr_i <= 8'h3a;
		end
	endtask : idle
	task automatic give_verdict();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : give_verdict
	always @(posedge mclk_i) begin
		cyc++;
		if (cyc == 3000) begin
			fail_count++;
			give_verdict();
		end
	end
	initial begin
		repeat (8) @(posedge mclk_i);
		sys_rst_i <= 1'b0;
		for (int a = 'h35; a <= 'h43; a++) rd(8'(a), a == 'h3a ? 8'h40 : 8'h00);
		for (int c = 0; c < 4; c++) begin
			wr(8'h36, 8'(c));
			chk(clk_source_o, 8'(c));
			if (c != 2) chk(use_ext_clk_o, c == 0);
		end
		tb_run <= 1'b1;
		wr(8'h36, 8'h01);
		idle(8);
		rd(8'h3a, 8'h40);
		wr(8'h36, 8'h02);
		idle(8);
		chk(use_ext_clk_o, 1'b1);
		rd(8'h3a, 8'h48);
		tb_run <= 1'b0;
		idle(24);
		rd(8'h3a, 8'h40);
		wr(8'h37, 8'h7f);
		chk(pc1, 8'h5f);
		wr(8'h38, 8'h5f);
		rd(8'h38, 8'h5f);
		wr(8'h3c, 8'ha5);
		chk(global_var_o, 8'ha5);
		rd(8'h3c, 8'ha5);
		wr(8'h3d, 8'hff);
		chk(swr, 1'b1);
		idle(2);
		rd(8'h3c, 8'h00);
		rd(8'h37, 8'h00);
		wr(8'h3b, 8'h07);
		chk({general_output_pin_o, irq_pin_oe_o, irq_pin_o}, 8'h07);
		wr(8'h3b, 8'h04);
		chk({general_output_pin_o, irq_pin_oe_o, irq_pin_o}, 8'h02);
		wr(8'h3b, 8'h00);
		chk({general_output_pin_o, irq_pin_oe_o}, 8'h00);
		foreach (chans[i]) begin
			wr(8'h41, {3'h0, chans[i]});
			chk(led_check_channel_o, chans[i]);
		end
		wr(8'h41, 8'hc8);
		chk(led_check_run_o, 1'b1);
		idle(25);
		chk({led_check_run_o, irq_pin_oe_o, irq_pin_o}, 8'h02);
		rd(8'h42, 8'ha6);
		rd(8'h3a, 8'hc0);
		@(negedge mclk_i);
		chk(irq_pin_oe_o, 1'b0);
		rd(8'h3a, 8'h40);
		wr(8'h3e, 8'h04);
		rd(8'h3e, 8'h84);
		idle(35);
		rd(8'h3e, 8'h04);
		rd(8'h3f, 8'hd7);
		wr(8'h40, 8'h7f);
		rd(8'h40, 8'h59);
		wr(8'h40, 8'h80);
		rd(8'h40, 8'hd9);
		wr(8'h3e, 8'h01);
		chk(comp_temp_o, 8'hd9);
		wr(8'h3e, 8'h00);
		chk(comp_temp_o, 8'hd7);
		@(posedge mclk_i);
		engine_irq_i <= 3'h5;
		@(posedge mclk_i);
		engine_irq_i <= 3'h0;
		rd(8'h3a, 8'h45);
		rd(8'h3a, 8'h40);
		chip_enable_i <= 1'b0;
		rd(8'h3a, 8'h60);
		chip_enable_i <= 1'b1;
		wr(8'h3a, 8'h00);
		boot_running_i <= 1'b1;
		rd(8'h3a, 8'h20);
		boot_running_i <= 1'b0;
		idle(2);
		chk({irq_pin_oe_o, irq_pin_o}, 8'h02);
		rd(8'h3a, 8'h00);
		@(negedge mclk_i);
		chk(irq_pin_oe_o, 1'b0);
		give_verdict();
	end
endmodule : led_sequencer_status_ctrl_regs_bench
